// ==== uart_lin_pkg.sv ====
/*
  Shared constants for the serial channel with break-field support:
  register indices, field positions, reset values and encodings.
  Assumes a 32-bit APB slave; byte address of a register is four times its index.
*/
package uart_lin_pkg;

  // ==========================================================
  // Register indices
  // ==========================================================
  localparam logic [31:0] CTL_IDX = 32'h0FFFFAA0;
  localparam logic [31:0] OPT_IDX = 32'hFFFFFAA3;
  localparam logic [31:0] STS_IDX = 32'h0FFFFAA1;
  localparam logic [31:0] TXD_IDX = 32'h0FFFFAA2;
  localparam logic [31:0] RXD_IDX = 32'h0FFFFAA4;
  localparam logic [31:0] BAUD_IDX = 32'h0FFFFAA5;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] CTL_RESET = 8'h10;
  localparam logic [7:0] OPT_RESET = 8'h14;
  localparam logic [15:0] BAUD_RESET = 16'h0010;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CTL_OPERATE = 7;
  localparam int CTL_TXE = 6;
  localparam int CTL_RXE = 5;
  localparam int CTL_DIR = 4;
  localparam int CTL_PS_HI = 3;
  localparam int CTL_PS_LO = 2;
  localparam int CTL_CL = 1;
  localparam int CTL_SL = 0;
  localparam int OPT_BRF = 7;
  localparam int OPT_BRT = 6;
  localparam int OPT_BTT = 5;
  localparam int OPT_BLEN_HI = 4;
  localparam int OPT_BLEN_LO = 2;
  localparam int OPT_TXINV = 1;
  localparam int OPT_RXINV = 0;
  localparam int STS_PE = 0;
  localparam int STS_FE = 1;
  localparam int STS_RXV = 2;
  localparam int STS_TXBUSY = 3;
  localparam int STS_BRK = 4;

  // ==========================================================
  // Encodings and timing
  // ==========================================================
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  localparam int EN_LATENCY = 2;
  localparam logic [4:0] BRK_RX_MIN_BITS = 5'h0B;
  localparam logic [4:0] BRK_TX_BASE = 5'h0D;

  // Code 101 gives the shortest break; the codes wrap upward from there.
  function automatic logic [4:0] brk_bits(input logic [2:0] code);
    logic [2:0] step;
    step = code + 3'h3;
    return BRK_TX_BASE + {2'h0, step};
  endfunction

endpackage

// ==== uart_lin_tx.sv ====
/*
  Transmit engine: start, data, optional parity, stop bits, and break fields.
  Assumes divisor >= 1 clocks per bit and that load is ignored while busy.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_lin_tx #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic arst,
  input wire logic active,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic lsb_first,
  input wire logic [1:0] parity,
  input wire logic char8,
  input wire logic stop2,
  input wire logic [7:0] data,
  input wire logic load,
  input wire logic brk_go,
  input wire logic [4:0] brk_len,
  output logic busy,
  output logic line
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} tx_state_t;
  tx_state_t state_r, state_nxt;
  logic [DIV_W-1:0] cnt_r, cnt_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [7:0] shf_r, shf_nxt;
  logic line_r, line_nxt;
  logic tick;
  logic [2:0] last;
  logic [7:0] masked;
  logic par_bit;

  // ==========================================================
  // Framing
  // ==========================================================
  assign tick = (cnt_r == divisor - 1'b1);
  assign last = char8 ? 3'h7 : 3'h6;
  assign masked = char8 ? shf_r : {1'b0, shf_r[6:0]};

  always_comb begin
    unique case (parity)
      uart_lin_pkg::PAR_ODD: par_bit = ~^masked;
      uart_lin_pkg::PAR_EVEN: par_bit = ^masked;
      default: par_bit = 1'b0;
    endcase
  end

  function automatic logic pick(input logic [7:0] d, input logic [2:0] i,
                                input logic [2:0] top, input logic lsb);
    logic [2:0] j;
    j = lsb ? i : top - i;
    return d[j];
  endfunction

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = (state_r == TX_IDLE || tick) ? '0 : cnt_r + 1'b1;
    bit_nxt = bit_r;
    shf_nxt = shf_r;
    line_nxt = line_r;
    unique case (state_r)
      TX_IDLE: begin
        line_nxt = 1'b1;
        bit_nxt = '0;
        if (brk_go) begin
          state_nxt = TX_BRK;
          line_nxt = 1'b0;
        end else if (load) begin
          state_nxt = TX_START;
          shf_nxt = data;
          line_nxt = 1'b0;
        end
      end
      TX_START: if (tick) begin
        state_nxt = TX_DATA;
        line_nxt = pick(shf_r, 3'h0, last, lsb_first);
      end
      TX_DATA: if (tick) begin
        if (bit_r[2:0] == last) begin
          bit_nxt = '0;
          state_nxt = (parity == uart_lin_pkg::PAR_NONE) ? TX_STOP : TX_PAR;
          line_nxt = (parity == uart_lin_pkg::PAR_NONE) ? 1'b1 : par_bit;
        end else begin
          bit_nxt = bit_r + 1'b1;
          line_nxt = pick(shf_r, bit_r[2:0] + 3'h1, last, lsb_first);
        end
      end
      TX_PAR: if (tick) begin
        state_nxt = TX_STOP;
        line_nxt = 1'b1;
      end
      TX_STOP: if (tick) begin
        if (stop2 && bit_r == '0) begin
          bit_nxt = 5'h01;
        end else begin
          state_nxt = TX_IDLE;
        end
      end
      TX_BRK: if (tick) begin
        if (bit_r == brk_len - 1'b1) begin
          state_nxt = TX_STOP;
          bit_nxt = 5'h01;
          line_nxt = 1'b1;
        end else begin
          bit_nxt = bit_r + 1'b1;
        end
      end
    endcase
    if (!active) begin
      state_nxt = TX_IDLE;
      line_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      state_r <= TX_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      shf_r <= '0;
      line_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      shf_r <= shf_nxt;
      line_r <= line_nxt;
    end
  end

  assign busy = (state_r != TX_IDLE);
  assign line = line_r;
endmodule
`default_nettype wire

// ==== uart_lin_rx.sv ====
/*
  Receive engine: mid-bit sampling of characters and break-field detection.
  Assumes line is already sampled to clk and corrected for inversion.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_lin_rx #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic arst,
  input wire logic active,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic lsb_first,
  input wire logic [1:0] parity,
  input wire logic char8,
  input wire logic line,
  input wire logic brk_arm,
  output logic [7:0] data,
  output logic done,
  output logic perr,
  output logic ferr,
  output logic brk_busy
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} rx_state_t;
  rx_state_t state_r, state_nxt;
  logic [DIV_W-1:0] cnt_r, cnt_nxt, target;
  logic [4:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, data_r, data_nxt;
  logic done_r, done_nxt, perr_r, perr_nxt, ferr_r, ferr_nxt;
  logic hit;
  logic [2:0] last, pos;
  logic [7:0] masked;

  // ==========================================================
  // Sampling
  // ==========================================================
  assign target = (state_r == RX_START) ? (divisor >> 1) : divisor - 1'b1;
  assign hit = (cnt_r == target);
  assign last = char8 ? 3'h7 : 3'h6;
  assign pos = lsb_first ? bit_r[2:0] : last - bit_r[2:0];
  assign masked = char8 ? sh_r : {1'b0, sh_r[6:0]};

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = hit ? '0 : cnt_r + 1'b1;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    data_nxt = data_r;
    done_nxt = 1'b0;
    perr_nxt = 1'b0;
    ferr_nxt = 1'b0;
    unique case (state_r)
      RX_IDLE: begin
        cnt_nxt = '0;
        bit_nxt = '0;
        sh_nxt = '0;
        if (brk_arm) begin
          state_nxt = RX_BRK;
        end else if (!line) begin
          state_nxt = RX_START;
        end
      end
      RX_START: if (hit) begin
        state_nxt = line ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (hit) begin
        sh_nxt[pos] = line;
        bit_nxt = bit_r + 1'b1;
        if (bit_r[2:0] == last) begin
          state_nxt = (parity == uart_lin_pkg::PAR_NONE) ? RX_STOP : RX_PAR;
        end
      end
      RX_PAR: if (hit) begin
        state_nxt = RX_STOP;
        if (parity == uart_lin_pkg::PAR_ODD) begin
          perr_nxt = (line != ~^masked);
        end else if (parity == uart_lin_pkg::PAR_EVEN) begin
          perr_nxt = (line != ^masked);
        end
      end
      RX_STOP: if (hit) begin
        state_nxt = RX_IDLE;
        ferr_nxt = !line;
        data_nxt = sh_r;
        done_nxt = 1'b1;
      end
      RX_BRK: begin
        if (line) begin
          cnt_nxt = '0;
          bit_nxt = '0;
          if (bit_r >= uart_lin_pkg::BRK_RX_MIN_BITS) begin
            state_nxt = RX_IDLE;
          end
        end else if (hit && bit_r != 5'h1F) begin
          bit_nxt = bit_r + 1'b1;
        end
      end
    endcase
    if (!active) begin
      state_nxt = RX_IDLE;
    end
  end

  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      state_r <= RX_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      data_r <= '0;
      done_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      data_r <= data_nxt;
      done_r <= done_nxt;
      perr_r <= perr_nxt;
      ferr_r <= ferr_nxt;
    end
  end

  // A short low pulse while armed restarts the count and keeps the flag up.
  assign brk_busy = (state_r == RX_BRK);
  assign data = data_r;
  assign done = done_r;
  assign perr = perr_r;
  assign ferr = ferr_r;
endmodule
`default_nettype wire

// ==== uart_lin_ctrl.sv ====
/*
  Top of the serial channel: APB register file, operate and enable control,
  start-up latency, line inversion, and the transmit and receive engines.
  Assumes a zero-wait APB master and synchronous rx_line.
*/
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module uart_lin_ctrl #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_line,
  output logic tx_line
);

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic [29:0] word;
  logic hit_ctl, hit_opt, hit_sts, hit_txd, hit_rxd, hit_baud, hit_any;
  logic access, wr0, wr1, rd;

  assign word = paddr[31:2];
  assign hit_ctl = (word == uart_lin_pkg::CTL_IDX[29:0]);
  assign hit_opt = (word == uart_lin_pkg::OPT_IDX[29:0]);
  assign hit_sts = (word == uart_lin_pkg::STS_IDX[29:0]);
  assign hit_txd = (word == uart_lin_pkg::TXD_IDX[29:0]);
  assign hit_rxd = (word == uart_lin_pkg::RXD_IDX[29:0]);
  assign hit_baud = (word == uart_lin_pkg::BAUD_IDX[29:0]);
  assign hit_any = hit_ctl | hit_opt | hit_sts | hit_txd | hit_rxd | hit_baud;
  assign access = psel & penable & hit_any;
  assign wr0 = access & pwrite & pstrb[0];
  assign wr1 = access & pwrite & pstrb[1];
  assign rd = access & ~pwrite;

  // Every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // ==========================================================
  // Software registers
  // ==========================================================
  logic [7:0] ctl_r, ctl_nxt;
  logic [4:0] opt_r, opt_nxt;
  logic [DIV_W-1:0] baud_r, baud_nxt;
  logic [7:0] txd_r, txd_nxt;
  logic load_r, load_nxt;
  logic btx_r, btx_nxt;
  logic brx_r, brx_nxt;
  logic tx_line_r, tx_line_nxt;
  logic operate, txe, rxe;
  logic tx_act, rx_act;
  logic tx_raw, tx_busy, brk_busy;

  assign operate = ctl_r[uart_lin_pkg::CTL_OPERATE];
  assign txe = ctl_r[uart_lin_pkg::CTL_TXE];
  assign rxe = ctl_r[uart_lin_pkg::CTL_RXE];

  always_comb begin
    ctl_nxt = ctl_r;
    opt_nxt = opt_r;
    baud_nxt = baud_r;
    txd_nxt = txd_r;
    load_nxt = 1'b0;
    btx_nxt = 1'b0;
    brx_nxt = 1'b0;
    if (wr0 && hit_ctl) begin
      ctl_nxt = pwdata[7:0];
    end
    if (wr0 && hit_opt) begin
      opt_nxt = pwdata[4:0];
      brx_nxt = pwdata[uart_lin_pkg::OPT_BRT] & rx_act;
      btx_nxt = pwdata[uart_lin_pkg::OPT_BTT] & tx_act;
    end
    if (wr0 && hit_txd) begin
      txd_nxt = pwdata[7:0];
      load_nxt = tx_act;
    end
    if (hit_baud) begin
      if (wr0) begin
        baud_nxt[7:0] = pwdata[7:0];
      end
      if (wr1) begin
        baud_nxt[DIV_W-1:8] = pwdata[DIV_W-1:8];
      end
    end
    if (operate) begin
      tx_line_nxt = tx_raw ^ opt_r[uart_lin_pkg::OPT_TXINV];
    end else begin
      tx_line_nxt = ~opt_r[uart_lin_pkg::OPT_TXINV];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= uart_lin_pkg::CTL_RESET;
      opt_r <= uart_lin_pkg::OPT_RESET[4:0];
      baud_r <= DIV_W'(uart_lin_pkg::BAUD_RESET);
      txd_r <= '0;
      load_r <= 1'b0;
      btx_r <= 1'b0;
      brx_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else begin
      ctl_r <= ctl_nxt;
      opt_r <= opt_nxt;
      baud_r <= baud_nxt;
      txd_r <= txd_nxt;
      load_r <= load_nxt;
      btx_r <= btx_nxt;
      brx_r <= brx_nxt;
      tx_line_r <= tx_line_nxt;
    end
  end

  assign tx_line = tx_line_r;

  // ==========================================================
  // Operate reset and enable latency
  // ==========================================================
  // The channel reset is the OR of rst and the inverted operate bit.
  logic core_rst;
  assign core_rst = rst | ~operate;

  logic [1:0] tx_dly_r, tx_dly_nxt;
  logic [1:0] rx_dly_r, rx_dly_nxt;
  logic rx_in_r, rx_in_nxt;

  always_comb begin
    tx_dly_nxt = {tx_dly_r[0], txe};
    rx_dly_nxt = {rx_dly_r[0], rxe};
    rx_in_nxt = rx_line ^ opt_r[uart_lin_pkg::OPT_RXINV];
  end

  always_ff @(posedge clk or posedge core_rst) begin
    if (core_rst) begin
      tx_dly_r <= '0;
      rx_dly_r <= '0;
      rx_in_r <= 1'b1;
    end else begin
      tx_dly_r <= tx_dly_nxt;
      rx_dly_r <= rx_dly_nxt;
      rx_in_r <= rx_in_nxt;
    end
  end

  // Clearing an enable drops activity at once; setting it waits two edges.
  assign tx_act = tx_dly_r[uart_lin_pkg::EN_LATENCY-1] & txe;
  assign rx_act = rx_dly_r[uart_lin_pkg::EN_LATENCY-1] & rxe;

  // ==========================================================
  // Engines
  // ==========================================================
  logic [7:0] rx_data;
  logic rx_done, rx_perr, rx_ferr;

  uart_lin_tx #(
    .DIV_W(DIV_W)
  ) u_tx (
    .clk(clk),
    .arst(core_rst),
    .active(tx_act),
    .divisor(baud_r),
    .lsb_first(ctl_r[uart_lin_pkg::CTL_DIR]),
    .parity(ctl_r[uart_lin_pkg::CTL_PS_HI:uart_lin_pkg::CTL_PS_LO]),
    .char8(ctl_r[uart_lin_pkg::CTL_CL]),
    .stop2(ctl_r[uart_lin_pkg::CTL_SL]),
    .data(txd_r),
    .load(load_r),
    .brk_go(btx_r),
    .brk_len(uart_lin_pkg::brk_bits(opt_r[uart_lin_pkg::OPT_BLEN_HI:uart_lin_pkg::OPT_BLEN_LO])),
    .busy(tx_busy),
    .line(tx_raw)
  );

  uart_lin_rx #(
    .DIV_W(DIV_W)
  ) u_rx (
    .clk(clk),
    .arst(core_rst),
    .active(rx_act),
    .divisor(baud_r),
    .lsb_first(ctl_r[uart_lin_pkg::CTL_DIR]),
    .parity(ctl_r[uart_lin_pkg::CTL_PS_HI:uart_lin_pkg::CTL_PS_LO]),
    .char8(ctl_r[uart_lin_pkg::CTL_CL]),
    .line(rx_in_r),
    .brk_arm(brx_r),
    .data(rx_data),
    .done(rx_done),
    .perr(rx_perr),
    .ferr(rx_ferr),
    .brk_busy(brk_busy)
  );

  // ==========================================================
  // Receive status
  // ==========================================================
  logic pe_r, pe_nxt, fe_r, fe_nxt, rxv_r, rxv_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic sts_wr;

  assign sts_wr = wr0 & hit_sts;

  // A hardware set in the same cycle as a software clear wins.
  always_comb begin
    pe_nxt = pe_r & ~(sts_wr & ~pwdata[uart_lin_pkg::STS_PE]);
    fe_nxt = fe_r & ~(sts_wr & ~pwdata[uart_lin_pkg::STS_FE]);
    rxv_nxt = rxv_r & ~(rd & hit_rxd);
    rxd_nxt = rxd_r;
    if (rx_perr) begin
      pe_nxt = 1'b1;
    end
    if (rx_ferr) begin
      fe_nxt = 1'b1;
    end
    if (rx_done) begin
      rxv_nxt = 1'b1;
      rxd_nxt = rx_data;
    end
    if (!rxe) begin
      pe_nxt = 1'b0;
      fe_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge core_rst) begin
    if (core_rst) begin
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      rxv_r <= 1'b0;
      rxd_r <= '0;
    end else begin
      pe_r <= pe_nxt;
      fe_r <= fe_nxt;
      rxv_r <= rxv_nxt;
      rxd_r <= rxd_nxt;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  logic brk_flag;
  assign brk_flag = brk_busy & rxe & operate;

  always_comb begin
    prdata = '0;
    if (rd) begin
      if (hit_ctl) begin
        prdata[7:0] = ctl_r;
      end
      if (hit_opt) begin
        prdata[uart_lin_pkg::OPT_BRF] = brk_flag;
        prdata[4:0] = opt_r;
      end
      if (hit_sts) begin
        prdata[uart_lin_pkg::STS_PE] = pe_r;
        prdata[uart_lin_pkg::STS_FE] = fe_r;
        prdata[uart_lin_pkg::STS_RXV] = rxv_r;
        prdata[uart_lin_pkg::STS_TXBUSY] = tx_busy;
        prdata[uart_lin_pkg::STS_BRK] = brk_flag;
      end
      if (hit_txd) begin
        prdata[7:0] = txd_r;
      end
      if (hit_rxd) begin
        prdata[7:0] = rxd_r;
      end
      if (hit_baud) begin
        prdata[DIV_W-1:0] = baud_r;
      end
    end
  end

endmodule
`default_nettype wire

// ==== uart_lin_chk_sva.sv ====
/* Checker for the serial channel top: register readback, line idle level and gating.
   Assumes it is bound to uart_lin_ctrl and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module uart_lin_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_line
);
  // ==========
  // Shadow registers
  // ==========
  localparam logic [31:0] A_CTL = {uart_lin_pkg::CTL_IDX[29:0], 2'h0};
  localparam logic [31:0] A_OPT = {uart_lin_pkg::OPT_IDX[29:0], 2'h0};
  localparam logic [31:0] A_STS = {uart_lin_pkg::STS_IDX[29:0], 2'h0};
  localparam logic [31:0] A_TXD = {uart_lin_pkg::TXD_IDX[29:0], 2'h0};
  logic wr;
  logic rd;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic [4:0] opt_r;
  logic [4:0] opt_nxt;
  assign wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  assign rd = psel && penable && pready && !pwrite;
  always_comb begin
    ctl_nxt = (wr && paddr == A_CTL) ? pwdata[7:0] : ctl_r;
    opt_nxt = (wr && paddr == A_OPT) ? pwdata[4:0] : opt_r;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= uart_lin_pkg::CTL_RESET;
      opt_r <= uart_lin_pkg::OPT_RESET[4:0];
    end else begin
      ctl_r <= ctl_nxt;
      opt_r <= opt_nxt;
    end
  end
  // ==========
  // Properties
  // ==========
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // The line is registered, so the first cycle after a write is left out.
  sequence s_quiet;
    ##1 (tx_line == !opt_r[1]) [*4];
  endsequence
  property p_rd_ctl;
    rd && paddr == A_CTL |-> prdata == {24'h0, ctl_r};
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
  property p_rd_opt;
    rd && paddr == A_OPT |-> prdata[6:0] == {2'h0, opt_r} && prdata[31:8] == 24'h0;
  endproperty
  a_rd_opt: assert property (p_rd_opt) else $error("option readback wrong");
  property p_idle;
    !ctl_r[7] && $past(ctl_r[7]) == 1'b0 && $stable(opt_r[1]) |-> tx_line == !opt_r[1];
  endproperty
  a_idle: assert property (p_idle) else $error("idle line level wrong");
  property p_brf;
    rd && paddr == A_OPT && !(ctl_r[7] && ctl_r[5]) |-> !prdata[7];
  endproperty
  a_brf: assert property (p_brf) else $error("break flag set while off");
  property p_sts;
    rd && paddr == A_STS && !ctl_r[7] |-> prdata == 32'h0;
  endproperty
  a_sts: assert property (p_sts) else $error("status not cleared");
  property p_err;
    pslverr |-> psel && penable && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error response malformed");
  property p_no_brk;
    wr && paddr == A_OPT && pwdata[5] && !ctl_r[6] |=> s_quiet;
  endproperty
  a_no_brk: assert property (p_no_brk) else $error("break sent while disabled");
  property p_txd_gate;
    wr && paddr == A_TXD && !ctl_r[6] |=> s_quiet;
  endproperty
  a_txd_gate: assert property (p_txd_gate) else $error("char sent while disabled");
  c_brk: cover property (wr && paddr == A_OPT && pwdata[5] && ctl_r[6]);
  c_arm: cover property (wr && paddr == A_OPT && pwdata[6]);
  c_err: cover property (pslverr);
endmodule
bind uart_lin_ctrl uart_lin_chk i_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_line(tx_line));
`default_nettype wire

// ==== serial_node.sv ====
/* Remote serial node: samples frames and break lengths, drives receive frames.
   Assumes B clocks per bit; the receive line idles high between frames. */
`timescale 1ns/1ps
`default_nettype none
module serial_node #(
  parameter int B = 16
) (
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;
  // ==========
  // Tasks
  // ==========
  // Sampling is on the falling edge so the registered line has settled.
  task automatic grab(input int n, input logic inv, output logic [15:0] v);
    v = 16'h0;
    @(negedge clk);
    while (tx_line === !inv) @(negedge clk);
    repeat (B / 2) @(negedge clk);
    for (int k = 0; k < n; k++) begin
      v[k] = tx_line ^ inv;
      repeat (B) @(negedge clk);
    end
  endtask
  task automatic brk(input logic inv, output int t);
    t = 0;
    @(negedge clk);
    while (tx_line === !inv) @(negedge clk);
    while (tx_line !== !inv) begin
      t++;
      @(negedge clk);
    end
  endtask
  task automatic send(input logic [15:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      rx_line <= v[k];
      repeat (B) @(posedge clk);
    end
    rx_line <= 1'b1;
    repeat (B) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== uart_lin_ctrl_bench.sv ====
/* Self-checking bench for the serial channel top with a remote node model.
   Assumes the baud divisor stays at its reset value of 16 clocks per bit. */
`timescale 1ns/1ps
`default_nettype none
module uart_lin_ctrl_bench;
  localparam logic [31:0] A_CTL = {uart_lin_pkg::CTL_IDX[29:0], 2'h0};
  localparam logic [31:0] A_OPT = {uart_lin_pkg::OPT_IDX[29:0], 2'h0};
  localparam logic [31:0] A_STS = {uart_lin_pkg::STS_IDX[29:0], 2'h0};
  localparam logic [31:0] A_TXD = {uart_lin_pkg::TXD_IDX[29:0], 2'h0};
  localparam logic [31:0] A_RXD = {uart_lin_pkg::RXD_IDX[29:0], 2'h0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, rx_line, tx_line, e;
  int miscompares = 0, total_checks = 0, cyc = 0;
  int bl[8] = '{16, 17, 18, 19, 20, 13, 14, 15};
  uart_lin_ctrl i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line));
  serial_node i_node (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  // ==========
  // Tasks
  // ==========
  task automatic finish_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  // Read data and the error flag are taken at the edge that completes the access.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wire levels, first bit in bit 0: start, data, parity, stop bits.
  function automatic logic [15:0] frame(input int d, input int c, output int n);
    int p;
    int b;
    int nd;
    logic [15:0] v;
    v = 16'h0;
    p = 0;
    n = 1;
    nd = 7 + c[1];
    for (int k = 0; k < nd; k++) begin
      b = c[4] ? d[k] : d[nd - 1 - k];
      v[n] = b[0];
      p ^= b;
      n++;
    end
    if (c[3:2] != 0) begin
      v[n] = (c[3:2] == 2) ? !p[0] : (c[3:2] == 3) ? p[0] : 1'b0;
      n++;
    end
    v[n] = 1'b1;
    v[n + 1] = c[0];
    n += 1 + c[0];
    return v;
  endfunction
  // ==========
  // Tests
  // ==========
  initial begin
    int d, c, n, x, o, inv;
    logic [15:0] v, g;
    d = $urandom(32'h1B57);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(0, A_CTL, 0);
    chk(r, 32'h10);
    apb(0, A_OPT, 0);
    chk(r, 32'h14);
    apb(0, A_STS, 0);
    chk(r, 32'h0);
    apb(0, 32'h10, 0);
    chk({31'h0, e}, 32'h1);
    apb(1, A_OPT, 32'h02);
    repeat (2) @(posedge clk);
    chk({31'h0, tx_line}, 32'h0);
    $display("reset and idle test done");
    for (int i = 0; i < 16; i++) begin
      c = 32'h80 | i | (($urandom % 2) << 4);
      d = $urandom % 256;
      inv = $urandom % 2;
      o = ((i % 8) << 2) | (inv << 1);
      apb(1, A_CTL, c);
      apb(1, A_OPT, o | 32'h20);
      apb(1, A_TXD, d);
      apb(1, A_CTL, c | 32'h40);
      apb(1, A_TXD, d);
      v = frame(d, c, n);
      i_node.grab(n, inv[0], g);
      chk({16'h0, g}, {16'h0, v});
      apb(1, A_OPT, o | 32'h20);
      i_node.brk(inv[0], n);
      chk(n, bl[i % 8] * 16);
      apb(1, A_CTL, c);
    end
    $display("transmit test done");
    for (int p = 0; p < 4; p++) begin
      c = 32'hB2 | (p << 2);
      d = $urandom % 256;
      x = (p == 1) ? 1 : $urandom % 2;
      v = frame(d, c, n);
      if (p != 0) v[9] ^= x[0];
      apb(1, A_CTL, c & 32'hDF);
      apb(1, A_CTL, c);
      repeat (2) @(posedge clk);
      i_node.send(v, n);
      apb(0, A_RXD, 0);
      chk(r, d);
      apb(0, A_STS, 0);
      chk({29'h0, r[2:0]}, (p > 1) ? x : 0);
      apb(1, A_STS, 0);
    end
    $display("receive test done");
    apb(1, A_OPT, 32'h40);
    apb(0, A_OPT, 0);
    chk({31'h0, r[7]}, 32'h1);
    i_node.send(16'h0, 5);
    apb(0, A_OPT, 0);
    chk({31'h0, r[7]}, 32'h1);
    i_node.send(16'h0, 12);
    apb(0, A_OPT, 0);
    chk({31'h0, r[7]}, 32'h0);
    $display("break receive test done");
    finish_test();
  end
endmodule
`default_nettype wire
